//--- rtl/jtp_pkg.sv
// Constants and types shared by the test and emulation port logic
package jtp_pkg;

	// Bit positions of the sampled pins in the synchroniser vector
	localparam int unsigned NPIN      = 6;
	localparam int unsigned IDX_TCK   = 0;
	localparam int unsigned IDX_TMS   = 1;
	localparam int unsigned IDX_TDI   = 2;
	localparam int unsigned IDX_TRST  = 3;
	localparam int unsigned IDX_EVA   = 4;
	localparam int unsigned IDX_EVB   = 5;

	// Instruction codes and the fixed pattern loaded in Capture-IR
	localparam logic [3:0] IR_IDCODE  = 4'h1;
	localparam logic [3:0] IR_EVCTRL  = 4'h8;
	localparam logic [3:0] IR_BYPASS  = 4'hF;
	localparam logic [3:0] IR_CAPTURE = 4'h1;

	// Identification word; value is arbitrary, bit 0 is set as the scan standard asks
	localparam logic [31:0] ID_CODE_VAL = 32'h0ABC_D001;

	// Reset values
	localparam logic [4:0] PULL_EN_RST = 5'h1F;
	localparam logic [3:0] EVCTRL_RST  = 4'h0;
	localparam logic [5:0] PIN_RST     = 6'h00;

	// Event control field positions
	localparam int unsigned EV_B_OE  = 0;
	localparam int unsigned EV_B_VAL = 1;
	localparam int unsigned EV_A_OE  = 2;
	localparam int unsigned EV_A_VAL = 3;

	typedef enum logic [3:0] {
		TAP_TLR, TAP_RTI,
		TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR,
		TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
	} jtp_tap_t;

	typedef enum logic [1:0] {
		DR_BYPASS, DR_IDCODE, DR_EVCTRL
	} jtp_dr_t;

endpackage

//--- rtl/jtp_pin_if.sv
// Synchronised test pin levels and test clock edge pulses
interface jtp_pin_if;
	logic tck;
	logic tms;
	logic tdi;
	logic trst;
	logic ev_a;
	logic ev_b;
	logic tck_rise;
	logic tck_fall;

	modport src (output tck, tms, tdi, trst, ev_a, ev_b, tck_rise, tck_fall);
	modport snk (input  tck, tms, tdi, trst, ev_a, ev_b, tck_rise, tck_fall);
endinterface

//--- rtl/jtp_sync.sv
// Three-stage pin synchroniser with agreement filter and test clock edge detect
module jtp_sync
	import jtp_pkg::*;
(
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic [NPIN-1:0] pins_i,
	jtp_pin_if.src               pin
);

	typedef struct packed {
		logic [NPIN-1:0] ff1;
		logic [NPIN-1:0] ff2;
		logic [NPIN-1:0] ff3;
		logic [NPIN-1:0] lvl;
		logic            rise;
		logic            fall;
	} jtp_sync_st_t;

	jtp_sync_st_t s_r;
	jtp_sync_st_t s_nxt;

	always_comb begin
		s_nxt      = s_r;
		s_nxt.ff1  = pins_i;
		s_nxt.ff2  = s_r.ff1;
		s_nxt.ff3  = s_r.ff2;
		// A level moves only once stages two and three agree, so a bit caught mid-change is not taken
		for (int i = 0; i < NPIN; i++) begin
			if (s_r.ff2[i] == s_r.ff3[i]) begin
				s_nxt.lvl[i] = s_r.ff3[i];
			end
		end
		s_nxt.rise = s_nxt.lvl[IDX_TCK] & ~s_r.lvl[IDX_TCK];
		s_nxt.fall = ~s_nxt.lvl[IDX_TCK] & s_r.lvl[IDX_TCK];
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_r <= '{ff1: PIN_RST, ff2: PIN_RST, ff3: PIN_RST, lvl: PIN_RST, rise: 1'b0, fall: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pin.tck      = s_r.lvl[IDX_TCK];
	assign pin.tms      = s_r.lvl[IDX_TMS];
	assign pin.tdi      = s_r.lvl[IDX_TDI];
	assign pin.trst     = s_r.lvl[IDX_TRST];
	assign pin.ev_a     = s_r.lvl[IDX_EVA];
	assign pin.ev_b     = s_r.lvl[IDX_EVB];
	assign pin.tck_rise = s_r.rise;
	assign pin.tck_fall = s_r.fall;

endmodule

//--- rtl/jtp_top.sv
// Test and emulation port: TAP controller, scan registers, event lines and pull control
module jtp_top
	import jtp_pkg::*;
(
	input  wire logic       CORE_CLK_I,
	input  wire logic       RST_I,
	input  wire logic       TCK_I,
	input  wire logic       TMS_I,
	input  wire logic       TDI_I,
	input  wire logic       TRST_I,
	input  wire logic       DEBUG_EVENT_LINE_A_I,
	output logic            DEBUG_EVENT_LINE_A_O,
	output logic            DEBUG_EVENT_LINE_A_OE_O,
	input  wire logic       DEBUG_EVENT_LINE_B_I,
	output logic            DEBUG_EVENT_LINE_B_O,
	output logic            DEBUG_EVENT_LINE_B_OE_O,
	output logic            TDO_O,
	output logic            TDO_OE_O,
	input  wire logic [4:0] PULL_DISABLE_I,
	output logic      [4:0] INTERNAL_PULLUP_EN_O,
	output logic            TEST_MODE_O,
	output logic            EMU_ROUTE_O
);

	typedef struct packed {
		jtp_tap_t    tap;
		logic [3:0]  ir;
		logic [3:0]  ir_sr;
		logic [31:0] dr_sr;
		logic [3:0]  ev_ctrl;
		logic        route_emu;
		logic        trst_d;
		logic        tdo;
		logic        tdo_oe;
		logic        ev_a_o;
		logic        ev_a_oe;
		logic        ev_b_o;
		logic        ev_b_oe;
		logic [4:0]  pull_disable_control_reg;
		logic [4:0]  pull_en;
		logic        test_mode;
	} jtp_st_t;

	jtp_st_t s_r;
	jtp_st_t s_nxt;

	jtp_pin_if pin ();

	jtp_sync u_sync (
		.clk_i  (CORE_CLK_I),
		.rst_i  (RST_I),
		.pins_i ({DEBUG_EVENT_LINE_B_I, DEBUG_EVENT_LINE_A_I, TRST_I, TDI_I, TMS_I, TCK_I}),
		.pin    (pin)
	);

	function automatic jtp_tap_t tap_next(input jtp_tap_t st, input logic tms);
		unique case (st)
			TAP_TLR:    tap_next = tms ? TAP_TLR    : TAP_RTI;
			TAP_RTI:    tap_next = tms ? TAP_SEL_DR : TAP_RTI;
			TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR:  tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAU_DR;
			TAP_PAU_DR: tap_next = tms ? TAP_EX2_DR : TAP_PAU_DR;
			TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
			TAP_SEL_IR: tap_next = tms ? TAP_TLR    : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR:  tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAU_IR;
			TAP_PAU_IR: tap_next = tms ? TAP_EX2_IR : TAP_PAU_IR;
			TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_RTI;
		endcase
	endfunction

	// Event control register exists only behind the emulation route
	function automatic jtp_dr_t dr_sel(input logic [3:0] ir, input logic route_emu);
		if (ir == IR_IDCODE) begin
			dr_sel = DR_IDCODE;
		end else if (ir == IR_EVCTRL && route_emu) begin
			dr_sel = DR_EVCTRL;
		end else begin
			dr_sel = DR_BYPASS;
		end
	endfunction

	function automatic logic is_shift(input jtp_tap_t st);
		is_shift = (st == TAP_SH_DR) || (st == TAP_SH_IR);
	endfunction

	jtp_dr_t sel;

	always_comb begin
		s_nxt     = s_r;
		sel       = dr_sel(s_r.ir, s_r.route_emu);
		s_nxt.trst_d    = pin.trst;
		s_nxt.test_mode = pin.trst;
		s_nxt.pull_disable_control_reg = PULL_DISABLE_I;
		s_nxt.pull_en   = ~s_r.pull_disable_control_reg;
		if (pin.trst && !s_r.trst_d) begin
			s_nxt.route_emu = pin.ev_a;
		end
		if (!pin.trst) begin
			// Held in reset: scan inputs have no effect and nothing drives the pins
			s_nxt.tap     = TAP_TLR;
			s_nxt.ir      = IR_IDCODE;
			s_nxt.ev_ctrl = EVCTRL_RST;
			s_nxt.tdo_oe  = 1'b0;
		end else begin
			if (pin.tck_rise) begin
				s_nxt.tap = tap_next(s_r.tap, pin.tms);
				case (s_r.tap)
					TAP_TLR: begin
						s_nxt.ir = IR_IDCODE;
					end
					TAP_CAP_IR: begin
						s_nxt.ir_sr = IR_CAPTURE;
					end
					TAP_SH_IR: begin
						s_nxt.ir_sr = {pin.tdi, s_r.ir_sr[3:1]};
					end
					TAP_UPD_IR: begin
						s_nxt.ir = s_r.ir_sr;
					end
					TAP_CAP_DR: begin
						unique case (sel)
							DR_IDCODE: s_nxt.dr_sr = ID_CODE_VAL;
							DR_EVCTRL: s_nxt.dr_sr = {26'h000_0000, pin.ev_b, pin.ev_a, s_r.ev_ctrl};
							DR_BYPASS: s_nxt.dr_sr = 32'h0000_0000;
						endcase
					end
					TAP_SH_DR: begin
						unique case (sel)
							DR_IDCODE: s_nxt.dr_sr = {pin.tdi, s_r.dr_sr[31:1]};
							DR_EVCTRL: s_nxt.dr_sr = {26'h000_0000, pin.tdi, s_r.dr_sr[5:1]};
							DR_BYPASS: s_nxt.dr_sr = {31'h0000_0000, pin.tdi};
						endcase
					end
					TAP_UPD_DR: begin
						if (sel == DR_EVCTRL) begin
							s_nxt.ev_ctrl = s_r.dr_sr[3:0];
						end
					end
					default: begin
					end
				endcase
			end
			if (pin.tck_fall) begin
				// Output moves half a test clock after the capture edge so the tester samples a settled bit
				s_nxt.tdo_oe = is_shift(s_r.tap);
				s_nxt.tdo    = (s_r.tap == TAP_SH_IR) ? s_r.ir_sr[0] : s_r.dr_sr[0];
			end
		end
		// Emulation logic decides which way each event line points
		s_nxt.ev_b_oe = pin.trst & s_r.route_emu & s_r.ev_ctrl[EV_B_OE];
		s_nxt.ev_b_o  = s_r.ev_ctrl[EV_B_VAL];
		s_nxt.ev_a_oe = pin.trst & s_r.trst_d & s_r.route_emu & s_r.ev_ctrl[EV_A_OE];
		s_nxt.ev_a_o  = s_r.ev_ctrl[EV_A_VAL];
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			s_r <= '{tap: TAP_TLR, ir: IR_IDCODE, ir_sr: 4'h0, dr_sr: 32'h0000_0000, ev_ctrl: EVCTRL_RST,
				route_emu: 1'b0, trst_d: 1'b0, tdo: 1'b0, tdo_oe: 1'b0, ev_a_o: 1'b0, ev_a_oe: 1'b0,
				ev_b_o: 1'b0, ev_b_oe: 1'b0, pull_disable_control_reg: 5'h00, pull_en: PULL_EN_RST,
				test_mode: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign TDO_O                   = s_r.tdo;
	assign TDO_OE_O                = s_r.tdo_oe;
	assign DEBUG_EVENT_LINE_A_O    = s_r.ev_a_o;
	assign DEBUG_EVENT_LINE_A_OE_O = s_r.ev_a_oe;
	assign DEBUG_EVENT_LINE_B_O    = s_r.ev_b_o;
	assign DEBUG_EVENT_LINE_B_OE_O = s_r.ev_b_oe;
	assign INTERNAL_PULLUP_EN_O    = s_r.pull_en;
	assign TEST_MODE_O             = s_r.test_mode;
	assign EMU_ROUTE_O             = s_r.route_emu;

	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (RST_I);

	tdo_on_fall_a: assert property (TDO_O != $past(TDO_O) |-> $past(pin.tck_fall))
		else $error("TDO changed without a test clock fall");
	tdo_float_a: assert property (pin.tck_fall && !is_shift(s_r.tap) |=> !TDO_OE_O)
		else $error("TDO driven outside a shift state");
	tdo_drive_a: assert property (pin.trst && pin.tck_fall && s_r.tap == TAP_SH_DR |=>
		TDO_OE_O && TDO_O == $past(s_r.dr_sr[0]))
		else $error("TDO not driving shift data");
	tdi_capture_a: assert property (pin.trst && pin.tck_rise && s_r.tap == TAP_SH_IR |=>
		s_r.ir_sr[3] == $past(pin.tdi))
		else $error("TDI not captured on rising edge");
	tms_step_a: assert property (pin.trst && pin.tck_rise && s_r.tap == TAP_RTI && pin.tms |=>
		s_r.tap == TAP_SEL_DR)
		else $error("TMS high in idle did not select DR scan");
	test_mode_a: assert property (pin.trst ##1 pin.trst |-> TEST_MODE_O)
		else $error("Test mode not granted while reset is high");
	functional_a: assert property (!pin.trst |=> s_r.tap == TAP_TLR && !TDO_OE_O ##1 !DEBUG_EVENT_LINE_B_OE_O)
		else $error("Test port active while test reset is low");
	evb_dir_a: assert property (DEBUG_EVENT_LINE_B_OE_O |-> EMU_ROUTE_O && $past(s_r.ev_ctrl[EV_B_OE]))
		else $error("Event line B driven without emulation control");
	pull_ctrl_a: assert property (INTERNAL_PULLUP_EN_O == ~$past(PULL_DISABLE_I, 2))
		else $error("Pull-up enables do not follow the disable control");
	route_latch_a: assert property (pin.trst && !s_r.trst_d |=> EMU_ROUTE_O == $past(pin.ev_a))
		else $error("Route not latched from event line A");
	tap_upd_a: assert property (pin.trst && pin.tck_rise && s_r.tap == TAP_UPD_DR && !pin.tms |=>
		s_r.tap == TAP_RTI)
		else $error("Update-DR with TMS low did not return to idle");

	shift_dr_c: cover property (s_r.tap == TAP_SH_DR && TDO_OE_O);
	ir_update_c: cover property (s_r.tap == TAP_UPD_IR && s_r.ir_sr == IR_EVCTRL);
	route_emu_c: cover property ($rose(EMU_ROUTE_O));
	evb_drive_c: cover property ($rose(DEBUG_EVENT_LINE_B_OE_O));

endmodule

//--- tb/jtp_probe.sv
// Debug probe model that drives the test port pins
module jtp_probe (
	input  wire logic tdo_i,
	input  wire logic tdo_oe_i,
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o,
	output logic      trst_o,
	output logic      ev_a_o,
	output logic      ev_a_en_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
		trst_o = 1'b0;
		ev_a_o = 1'b1;
		ev_a_en_o = 1'b0;
	end
	// One even-duty test clock period; the clock stands low between calls
	// Output is sampled late in the high phase, as it only settles well after the fall
	// Pins move by non-blocking assignment, as every step lands on a system clock edge
	task automatic cyc(input logic tms, input logic tdi, output logic tdo, output logic oe);
		tms_o <= tms;
		tdi_o <= tdi;
		#80 tck_o <= 1'b1;
		#75 tdo = tdo_i;
		oe = tdo_oe_i;
		#5 tck_o <= 1'b0;
	endtask
	// Test reset pulsed low while line A carries the route choice, then on to idle
	task automatic trst_pulse(input logic route);
		logic d, e;
		ev_a_o <= route;
		ev_a_en_o <= 1'b1;
		trst_o <= 1'b0;
		#400 trst_o <= 1'b1;
		#400 ev_a_en_o <= 1'b0;
		cyc(1'b0, 1'b0, d, e);
	endtask
endmodule

//--- tb/testbench.sv
// Self-checking bench for the test and emulation port
module testbench
	import jtp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk, rst, tck, tms, tdi, trst, pa, pa_en, tdo_w;
	logic       a_o, a_oe, b_o, b_oe, tdo, tdo_oe, tmode, route;
	logic [4:0] pull_dis, pu_en;
	logic       ln_a, ln_b;
	int         n_mismatch = 0;
	int         samples_checked = 0;
	int         cycles = 0;
	// Released lines and output float to their pull-up level
	assign ln_a = a_oe ? a_o : (pa_en ? pa : 1'b1);
	assign ln_b = b_oe ? b_o : 1'b1;
	assign tdo_w = tdo_oe ? tdo : 1'b1;
	jtp_top u_dut (.CORE_CLK_I(clk), .RST_I(rst), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi), .TRST_I(trst),
		.DEBUG_EVENT_LINE_A_I(ln_a), .DEBUG_EVENT_LINE_A_O(a_o), .DEBUG_EVENT_LINE_A_OE_O(a_oe),
		.DEBUG_EVENT_LINE_B_I(ln_b), .DEBUG_EVENT_LINE_B_O(b_o), .DEBUG_EVENT_LINE_B_OE_O(b_oe),
		.TDO_O(tdo), .TDO_OE_O(tdo_oe), .PULL_DISABLE_I(pull_dis), .INTERNAL_PULLUP_EN_O(pu_en),
		.TEST_MODE_O(tmode), .EMU_ROUTE_O(route));
	jtp_probe u_probe (.tdo_i(tdo_w), .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
		.trst_o(trst), .ev_a_o(pa), .ev_a_en_o(pa_en));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_mismatch++;
			results();
		end
	end
	// From idle: select IR or DR, capture, shift n bits LSB first, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic d, e;
		dout = '0;
		u_probe.cyc(1'b1, 1'b0, d, e);
		if (ir)
			u_probe.cyc(1'b1, 1'b0, d, e);
		u_probe.cyc(1'b0, 1'b0, d, e);
		u_probe.cyc(1'b0, 1'b0, d, e);
		chk(32'(e), 32'h0);
		for (int k = 0; k < n; k++) begin
			u_probe.cyc(k == n - 1, din[k], d, e);
			dout[k] = d;
			chk(32'(e), 32'h1);
		end
		u_probe.cyc(1'b1, 1'b0, d, e);
		chk(32'(e), 32'h0);
		u_probe.cyc(1'b0, 1'b0, d, e);
	endtask
	task automatic t_pull();
		@(posedge clk);
		pull_dis <= 5'h0B;
		repeat (4) @(posedge clk);
		chk(32'(pu_en), 32'h14);
	endtask
	// Clocking with test reset low must leave the port idle
	task automatic t_func();
		logic d, e;
		for (int k = 0; k < 8; k++) begin
			u_probe.cyc(k[0], 1'b0, d, e);
			chk(32'(e), 32'h0);
		end
		chk(32'(tmode), 32'h0);
	endtask
	task automatic t_idcode();
		logic [31:0] d;
		logic        x, e;
		u_probe.trst_pulse(1'b0);
		chk(32'(tmode), 32'h1);
		chk(32'(route), 32'h0);
		repeat (5) u_probe.cyc(1'b1, 1'b0, x, e);
		u_probe.cyc(1'b0, 1'b0, x, e);
		scan(1'b0, 32, 32'h0, d);
		chk(d, ID_CODE_VAL);
	endtask
	// Event control code is refused on the boundary-scan route and acts as bypass
	task automatic t_bypass();
		logic [31:0] d;
		scan(1'b1, 4, 32'(IR_EVCTRL), d);
		chk(d, 32'(IR_CAPTURE));
		scan(1'b0, 8, 32'h00A5, d);
		chk(d, 32'h004A);
	endtask
	task automatic t_event();
		logic [31:0] d;
		u_probe.trst_pulse(1'b1);
		chk(32'(route), 32'h1);
		scan(1'b1, 4, 32'(IR_EVCTRL), d);
		scan(1'b0, 6, 32'h03, d);
		chk(d, 32'h30);
		// The update lands after the last test clock rise has crossed the synchroniser
		repeat (4) @(negedge clk);
		chk(32'({b_oe, b_o}), 32'h3);
		scan(1'b0, 6, 32'h04, d);
		chk(d, 32'h33);
		repeat (4) @(negedge clk);
		chk(32'({b_oe, a_oe, a_o}), 32'h2);
		scan(1'b0, 6, 32'h00, d);
		chk(d, 32'h24);
	endtask
	initial begin
		rst = 1'b1;
		pull_dis = 5'h00;
		repeat (5) @(posedge clk);
		#1 chk(32'(pu_en), 32'h1F);
		chk(32'(tdo_oe), 32'h0);
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_pull();
		t_func();
		t_idcode();
		t_bypass();
		t_event();
		results();
	end
endmodule
